// file: tsp_port.v
/*
 Telemetry serial port top: AHB-Lite register slave, transmitter with
 three flow-control modes, receiver, gap check and remote shutdown hold.
 Assumes pins synchronous to hclk, single-word AHB-Lite transfers.
*/
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
`include "tsp_defs.vh"
// Contract
// - Characters use one start, eight data, no parity, one stop bit.
// - Bit rate selectable from 1200 to 9600 baud; both ends match.
// - Station number held, range 1 to 255.
// - Flow control selects none, RTS pre-key, or RTS/CTS handshake.
// - No handshake: transmit starts without any handshake line activity.
// - Pre-key: assert RTS, wait pre-transmit delay, then send.
// - Full handshake: assert RTS, hold data until CTS asserted.
// - Gap between characters of a message stays within the set limit.
// - Nonzero shutdown value stops motor and blocks restarts until zero.
module tsp_port (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire rxd,
  output reg txd,
  output reg rts,
  input wire cts,
  input wire motor_run_request,
  output reg motor_enable
);
  localparam S_IDLE = 3'd0;
  localparam S_PREKEY = 3'd1;
  localparam S_WAITCTS = 3'd2;
  localparam S_SEND = 3'd3;
  localparam S_GAP = 3'd4;

  reg [7:0] ctrl;
  reg [7:0] station;
  reg [7:0] pre_transmit_delay;
  reg [7:0] inter_char_delay;
  reg [7:0] shutdown_value;
  reg [7:0] tx_hold;
  reg tx_full;
  reg tx_last;
  reg [7:0] rx_data;
  reg rx_valid;
  reg frame_err;
  reg gap_err;
  reg wr_pend;
  reg rd_pend;
  reg [7:0] wr_addr;
  reg [7:0] rd_addr;
  reg [31:0] rdata;
  reg [2:0] state;
  reg [9:0] shift;
  reg [3:0] bit_cnt;
  reg [15:0] baud_cnt;
  reg [18:0] tick_cnt;
  reg [7:0] delay_cnt;
  reg [31:0] div_full;
  reg cur_last;
  wire [15:0] bit_div;
  wire [31:0] tick_reload;
  wire [1:0] baud_sel;
  wire [1:0] flow_control_select;
  wire tick;
  wire take;
  wire [7:0] rx_byte;
  wire rx_done;
  wire rx_frame_err;
  wire tx_load;

  assign baud_sel = ctrl[`TSP_CTRL_BAUD_LSB+1:`TSP_CTRL_BAUD_LSB];
  assign flow_control_select = ctrl[`TSP_CTRL_FLOW_LSB+1:`TSP_CTRL_FLOW_LSB];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata;
  assign take = hsel & hready & htrans[1];
  assign tick = (tick_cnt == 19'h00000);
  assign bit_div = div_full[15:0];
  assign tick_reload = `TSP_TICK_CYCLES - 1;

  always @* begin
    if (baud_sel == `TSP_BAUD_9600) begin
      div_full = `TSP_DIV_9600;
    end else if (baud_sel == `TSP_BAUD_4800) begin
      div_full = `TSP_DIV_4800;
    end else if (baud_sel == `TSP_BAUD_2400) begin
      div_full = `TSP_DIV_2400;
    end else begin
      div_full = `TSP_DIV_1200;
    end
  end

  // Address phase capture and register writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
      ctrl <= `TSP_CTRL_RESET;
      station <= `TSP_STATION_RESET;
      {inter_char_delay, pre_transmit_delay} <= `TSP_DELAY_RESET;
      shutdown_value <= 8'h00;
      tx_hold <= 8'h00;
      tx_last <= 1'b0;
    end else begin
      wr_pend <= take & hwrite;
      rd_pend <= take & ~hwrite;
      wr_addr <= haddr[7:0];
      rd_addr <= haddr[7:0];
      if (wr_pend) begin
        if (wr_addr == `TSP_OFF_CTRL) begin
          ctrl <= hwdata[7:0];
        end else if (wr_addr == `TSP_OFF_STATION) begin
          if (hwdata[7:0] != 8'h00)
            station <= hwdata[7:0];
        end else if (wr_addr == `TSP_OFF_DELAY) begin
          pre_transmit_delay <= hwdata[7:0];
          inter_char_delay <= hwdata[15:8];
        end else if (wr_addr == `TSP_OFF_SHUTDOWN) begin
          shutdown_value <= hwdata[7:0];
        end else if (wr_addr == `TSP_OFF_TXDATA) begin
          if (!tx_full) begin
            tx_hold <= hwdata[7:0];
            tx_last <= hwdata[8];
          end
        end
      end
    end
  end

  // Read data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= 32'h00000000;
    end else if (take & ~hwrite) begin
      if (haddr[7:0] == `TSP_OFF_CTRL) begin
        rdata <= {24'h000000, ctrl};
      end else if (haddr[7:0] == `TSP_OFF_STATION) begin
        rdata <= {24'h000000, station};
      end else if (haddr[7:0] == `TSP_OFF_DELAY) begin
        rdata <= {16'h0000, inter_char_delay, pre_transmit_delay};
      end else if (haddr[7:0] == `TSP_OFF_SHUTDOWN) begin
        rdata <= {24'h000000, shutdown_value};
      end else if (haddr[7:0] == `TSP_OFF_RXDATA) begin
        rdata <= {24'h000000, rx_data};
      end else if (haddr[7:0] == `TSP_OFF_STATUS) begin
        rdata <= {25'h0000000, ~motor_enable, state != S_IDLE, rts, gap_err, frame_err, rx_valid, tx_full};
      end else begin
        rdata <= 32'h00000000;
      end
    end
  end

  // Motor hold while shutdown value nonzero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      motor_enable <= 1'b0;
    else
      motor_enable <= motor_run_request & (shutdown_value == 8'h00);
  end

  // Receiver and its flags; set wins over clear
  tsp_rx u_rx (
    .hclk(hclk),
    .hresetn(hresetn),
    .rxd(rxd),
    .bit_div(bit_div),
    .rx_byte(rx_byte),
    .rx_done(rx_done),
    .rx_frame_err(rx_frame_err)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_data <= rx_byte;
        rx_valid <= 1'b1;
      end else if (rd_pend && rd_addr == `TSP_OFF_RXDATA) begin
        rx_valid <= 1'b0;
      end
      if (rx_frame_err)
        frame_err <= 1'b1;
      else if (wr_pend && wr_addr == `TSP_OFF_STATUS && hwdata[`TSP_ST_FRAMERR])
        frame_err <= 1'b0;
    end
  end

  // Ten millisecond tick
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tick_cnt <= 19'h00000;
    else if (state == S_IDLE || tick)
      tick_cnt <= tick_reload[18:0];
    else
      tick_cnt <= tick_cnt - 19'h00001;
  end

  assign tx_load = wr_pend && wr_addr == `TSP_OFF_TXDATA && !tx_full;

  // Transmit sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      txd <= 1'b1;
      rts <= 1'b0;
      tx_full <= 1'b0;
      shift <= 10'h3ff;
      bit_cnt <= 4'h0;
      baud_cnt <= 16'h0000;
      delay_cnt <= 8'h00;
      gap_err <= 1'b0;
      cur_last <= 1'b0;
    end else begin
      if (tx_load)
        tx_full <= 1'b1;
      if (wr_pend && wr_addr == `TSP_OFF_STATUS && hwdata[`TSP_ST_GAPERR])
        gap_err <= 1'b0;
      case (state)
        S_IDLE: begin
          txd <= 1'b1;
          if (tx_full) begin
            delay_cnt <= pre_transmit_delay;
            if (flow_control_select == `TSP_FLOW_RTS) begin
              rts <= 1'b1;
              state <= S_PREKEY;
            end else if (flow_control_select == `TSP_FLOW_RCTS) begin
              rts <= 1'b1;
              state <= S_WAITCTS;
            end else begin
              state <= S_SEND;
              shift <= {1'b1, tx_hold, 1'b0};
              bit_cnt <= 4'h0;
              baud_cnt <= bit_div - 16'h0001;
              tx_full <= 1'b0;
              cur_last <= tx_last;
            end
          end
        end
        S_PREKEY: begin
          if (delay_cnt == 8'h00) begin
            state <= S_SEND;
            cur_last <= tx_last;
            shift <= {1'b1, tx_hold, 1'b0};
            bit_cnt <= 4'h0;
            baud_cnt <= bit_div - 16'h0001;
            tx_full <= 1'b0;
          end else if (tick) begin
            delay_cnt <= delay_cnt - 8'h01;
          end
        end
        S_WAITCTS: begin
          if (cts) begin
            state <= S_SEND;
            cur_last <= tx_last;
            shift <= {1'b1, tx_hold, 1'b0};
            bit_cnt <= 4'h0;
            baud_cnt <= bit_div - 16'h0001;
            tx_full <= 1'b0;
          end
        end
        S_SEND: begin
          txd <= shift[0];
          if (baud_cnt != 16'h0000) begin
            baud_cnt <= baud_cnt - 16'h0001;
          end else begin
            baud_cnt <= bit_div - 16'h0001;
            shift <= {1'b1, shift[9:1]};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h9) begin
              txd <= 1'b1;
              if (cur_last) begin
                rts <= 1'b0;
                state <= S_IDLE;
              end else begin
                delay_cnt <= inter_char_delay;
                state <= S_GAP;
              end
            end
          end
        end
        S_GAP: begin
          txd <= 1'b1;
          if (tx_full && !(tx_load)) begin
            state <= S_SEND;
            cur_last <= tx_last;
            shift <= {1'b1, tx_hold, 1'b0};
            bit_cnt <= 4'h0;
            baud_cnt <= bit_div - 16'h0001;
            tx_full <= 1'b0;
          end else if (delay_cnt == 8'h00 && tick) begin
            gap_err <= 1'b1;
            rts <= 1'b0;
            state <= S_IDLE;
          end else if (tick && delay_cnt != 8'h00) begin
            delay_cnt <= delay_cnt - 8'h01;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// file: tsp_defs.vh
/*
 Constants of the telemetry serial port: register offsets, field positions,
 reset values and timing counts. Assumes a 40 MHz clock.
*/
`ifndef TSP_DEFS_VH
`define TSP_DEFS_VH
`define TSP_CLK_HZ 40000000
`define TSP_OFF_CTRL 8'h00
`define TSP_OFF_STATION 8'h04
`define TSP_OFF_DELAY 8'h08
`define TSP_OFF_SHUTDOWN 8'h0c
`define TSP_OFF_TXDATA 8'h10
`define TSP_OFF_RXDATA 8'h14
`define TSP_OFF_STATUS 8'h18
`define TSP_CTRL_BAUD_LSB 0
`define TSP_CTRL_FLOW_LSB 4
`define TSP_CTRL_RESET 8'h00
`define TSP_STATION_RESET 8'h01
`define TSP_DELAY_RESET 16'h0000
`define TSP_BAUD_1200 2'h0
`define TSP_BAUD_2400 2'h1
`define TSP_BAUD_4800 2'h2
`define TSP_BAUD_9600 2'h3
`define TSP_FLOW_NONE 2'h0
`define TSP_FLOW_RTS 2'h1
`define TSP_FLOW_RCTS 2'h2
`define TSP_DIV_1200 (`TSP_CLK_HZ / 1200)
`define TSP_DIV_2400 (`TSP_CLK_HZ / 2400)
`define TSP_DIV_4800 (`TSP_CLK_HZ / 4800)
`define TSP_DIV_9600 (`TSP_CLK_HZ / 9600)
`define TSP_TICK_MS 10
`define TSP_TICK_CYCLES (`TSP_CLK_HZ / 1000 * `TSP_TICK_MS)
`define TSP_ST_TXFULL 0
`define TSP_ST_RXVALID 1
`define TSP_ST_FRAMERR 2
`define TSP_ST_GAPERR 3
`define TSP_ST_RTS 4
`define TSP_ST_BUSY 5
`define TSP_ST_STOPPED 6
`endif

// file: tsp_rx.v
/*
 Serial receiver: 8 data bits, no parity, 1 start, 1 stop.
 Assumes rxd already synchronous to hclk and idling high.
*/
`timescale 1ns/10ps
`include "tsp_defs.vh"
module tsp_rx (
  input wire hclk,
  input wire hresetn,
  input wire rxd,
  input wire [15:0] bit_div,
  output reg [7:0] rx_byte,
  output reg rx_done,
  output reg rx_frame_err
);
  reg busy;
  reg [3:0] bit_idx;
  reg [15:0] cnt;
  reg [7:0] shift;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      bit_idx <= 4'h0;
      cnt <= 16'h0000;
      shift <= 8'h00;
      rx_byte <= 8'h00;
      rx_done <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      rx_frame_err <= 1'b0;
      if (!busy) begin
        if (!rxd) begin
          busy <= 1'b1;
          bit_idx <= 4'h0;
          cnt <= {1'b0, bit_div[15:1]};
        end
      end else if (cnt != 16'h0000) begin
        cnt <= cnt - 16'h0001;
      end else begin
        cnt <= bit_div - 16'h0001;
        bit_idx <= bit_idx + 4'h1;
        if (bit_idx == 4'h0) begin
          if (rxd)
            busy <= 1'b0;
        end else if (bit_idx < 4'h9) begin
          shift <= {rxd, shift[7:1]};
        end else begin
          busy <= 1'b0;
          if (rxd) begin
            rx_byte <= shift;
            rx_done <= 1'b1;
          end else begin
            rx_frame_err <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// file: tsp_port_checker.sv
/* Port assertions for tsp_port.
 Assumes one hclk domain with async reset hresetn. */
`timescale 1ns/10ps
`include "tsp_defs.vh"
module tsp_port_checker (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire txd,
  input wire rts,
  input wire cts,
  input wire motor_run_request,
  input wire motor_enable
);
  reg wp;
  reg [7:0] wa;
  reg [1:0] flow;
  reg sd;
  // Shadow of flow field and shutdown value
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp <= 1'b0;
      wa <= 8'h00;
      flow <= 2'h0;
      sd <= 1'b0;
    end else begin
      wp <= hsel & hready & htrans[1] & hwrite;
      wa <= haddr[7:0];
      if (wp && wa == `TSP_OFF_CTRL)
        flow <= hwdata[5:4];
      if (wp && wa == `TSP_OFF_SHUTDOWN)
        sd <= |hwdata[7:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_none_quiet: assert property (flow == 0 && !rts |=> !rts)
    else $error("rts raised with no flow control");
  chk_cts_hold: assert property (flow == 2 && !cts && txd |=> txd)
    else $error("data sent without cts");
  chk_rts_first: assert property (flow != 0 && $fell(txd) |-> rts)
    else $error("data sent without rts");
  chk_cts_start: assert property (flow == 2 && rts && $rose(cts) && txd |-> ##[1:4] !txd)
    else $error("no start bit after cts");
  chk_rts_end: assert property ($fell(rts) |-> txd && $past(txd))
    else $error("rts dropped inside a character");
  chk_start_len: assert property ($fell(txd) |-> (!txd) [*8])
    else $error("start bit too short");
  chk_motor_off: assert property (sd |=> !motor_enable)
    else $error("motor runs under shutdown");
  chk_motor_on: assert property (!sd && motor_run_request |=> motor_enable)
    else $error("motor blocked without shutdown");
  cov_cts_wait: cover property (flow == 2 && rts && !cts);
  cov_prekey: cover property (flow == 1 && $rose(rts));
  cov_stop: cover property ($fell(motor_enable));
endmodule
bind tsp_port tsp_port_checker u_chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .txd(txd),
  .rts(rts),
  .cts(cts),
  .motor_run_request(motor_run_request),
  .motor_enable(motor_enable)
);

// file: tsp_modem.sv
/* Telemetry modem model on the serial pins.
 Assumes 9600 baud on a 40 MHz hclk. */
`timescale 1ns/10ps
module tsp_modem #(
  parameter int DIV = 4166
) (
  input wire hclk,
  input wire rts,
  input wire txd,
  output logic cts,
  output logic rxd,
  output logic [7:0] got,
  output int n_got
);
  int lag = 2;
  int w = 0;
  initial begin
    cts = 1'b0;
    rxd = 1'b1;
    got = 8'h00;
    n_got = 0;
  end
  // Clear to send a lag after request
  always @(posedge hclk) begin
    if (!rts) begin
      w <= 0;
      cts <= 1'b0;
    end else if (w >= lag) begin
      cts <= 1'b1;
    end else begin
      w <= w + 1;
    end
  end
  // Mid-bit sampling, counted on good stop
  initial begin
    forever begin
      @(negedge txd);
      repeat (DIV / 2) @(posedge hclk);
      for (int i = 0; i < 9; i++) begin
        repeat (DIV) @(posedge hclk);
        if (i < 8)
          got[i] = txd;
      end
      if (txd === 1'b1)
        n_got++;
    end
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge hclk);
      rxd <= f[i];
      repeat (DIV - 1) @(posedge hclk);
    end
  endtask
endmodule

// file: tsp_port_tb.sv
/* Self-checking bench for tsp_port.
 Assumes a 40 MHz hclk and a modem model on the pins. */
`timescale 1ns/10ps
`include "tsp_defs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tsp_port_tb;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, motor_run_request;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire [31:0] hrdata;
  wire hreadyout, hresp, txd, rts, cts, rxd, motor_enable;
  wire hready = hreadyout;
  wire [7:0] got;
  int n_got;
  int miscompares = 0;
  int n_tests = 0;
  tsp_port dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rxd(rxd),
    .txd(txd),
    .rts(rts),
    .cts(cts),
    .motor_run_request(motor_run_request),
    .motor_enable(motor_enable)
  );
  tsp_modem modem (
    .hclk(hclk),
    .rts(rts),
    .txd(txd),
    .cts(cts),
    .rxd(rxd),
    .got(got),
    .n_got(n_got)
  );
  initial begin
    forever #12.5 hclk = ~hclk;
  end
  task automatic summarize();
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
    r = hrdata;
    if (k >= 100) begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    `CHK(nm, e, r)
  endtask
  task automatic wait_got(input int n);
    for (int k = 0; k < 50000 && n_got < n; k++) @(posedge hclk);
    if (n_got < n) begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic wait_rts(input logic v);
    for (int k = 0; k < 50000 && rts !== v; k++) @(posedge hclk);
    if (rts !== v) begin
      miscompares++;
      summarize();
    end
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    motor_run_request = 1'b0;
    repeat (12) @(posedge hclk);
    `CHK("txd idle", 1'b1, txd)
    hresetn <= 1'b1;
    rd("ctrl", `TSP_OFF_CTRL, 32'h0);
    rd("station", `TSP_OFF_STATION, 32'h1);
    rd("delay", `TSP_OFF_DELAY, 32'h0);
    rd("shutdown", `TSP_OFF_SHUTDOWN, 32'h0);
    wr(`TSP_OFF_STATION, 32'hff);
    wr(`TSP_OFF_STATION, 32'h0);
    rd("station top", `TSP_OFF_STATION, 32'hff);
    wr(32'h1c, 32'hffffffff);
    rd("unmapped", 32'h1c, 32'h0);
    for (int b = 0; b < 4; b++) begin
      wr(`TSP_OFF_CTRL, 32'h20 | 32'(b));
      rd("baud", `TSP_OFF_CTRL, 32'h20 | 32'(b));
    end
    motor_run_request <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK("motor run", 1'b1, motor_enable)
    wr(`TSP_OFF_SHUTDOWN, 32'h80);
    motor_run_request <= 1'b0;
    repeat (2) @(posedge hclk);
    motor_run_request <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK("motor held", 1'b0, motor_enable)
    rd("stopped", `TSP_OFF_STATUS, 32'h40);
    wr(`TSP_OFF_SHUTDOWN, 32'h0);
    repeat (2) @(posedge hclk);
    `CHK("motor free", 1'b1, motor_enable)
    modem.lag = 300;
    wr(`TSP_OFF_TXDATA, 32'h1a5);
    fork
      modem.send(8'h3c);
    join_none
    wait_rts(1'b1);
    repeat (100) @(posedge hclk);
    `CHK("held for cts", 1'b1, txd)
    wait_got(1);
    `CHK("byte cts", 8'ha5, got)
    wait_rts(1'b0);
    `CHK("idle at rts drop", 1'b1, txd)
    rd("rx valid", `TSP_OFF_STATUS, 32'h2);
    rd("rx byte", `TSP_OFF_RXDATA, 32'h3c);
    rd("rx read", `TSP_OFF_STATUS, 32'h0);
    wr(`TSP_OFF_CTRL, 32'h13);
    wr(`TSP_OFF_TXDATA, 32'h15a);
    wait_rts(1'b1);
    `CHK("prekey idle", 1'b1, txd)
    repeat (3) @(posedge hclk);
    `CHK("prekey zero", 1'b0, txd)
    wait_got(2);
    `CHK("byte prekey", 8'h5a, got)
    wait_rts(1'b0);
    wr(`TSP_OFF_CTRL, 32'h02);
    wr(`TSP_OFF_TXDATA, 32'h0c3);
    repeat (4) @(posedge hclk);
    `CHK("plain start", 1'b0, txd)
    `CHK("plain rts", 1'b0, rts)
    repeat (6000) @(posedge hclk);
    `CHK("slow start bit", 1'b0, txd)
    summarize();
  end
endmodule
